/* hw/crf_map.svh */
// constants for the processor register files and operand formats
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_NREG        32
`define CRF_AW          5
`define CRF_SGL_EXP_MAX 8'hff
`define CRF_DBL_EXP_MAX 11'h7ff
`define CRF_SZ_B        2'h0
`define CRF_SZ_H        2'h1
`define CRF_SZ_W        2'h2
`define CRF_PS_8        2'h0
`define CRF_PS_16       2'h1
`define CRF_PS_32       2'h2
`define CRF_CTL_NUM     4'hc
`endif

/* hw/crf_pkg.sv */
// types for the processor register files
package crf_pkg;
  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [22:0] frac;
  } crf_single_t;
  typedef struct packed {
    logic        sign;
    logic [10:0] exp;
    logic [51:0] frac;
  } crf_double_t;
  typedef struct packed {
    logic        trap;
    logic        zero;
    logic        sign;
  } crf_fpclass_t;
  typedef enum logic [1:0] {
    CRF_ALU_ADDS,
    CRF_ALU_SUBS,
    CRF_ALU_ADDU,
    CRF_ALU_SUBU
  } crf_aluop_t;
endpackage : crf_pkg

/* hw/crf_fp_classify.sv */
// classifier for single and double real operands
`timescale 1ns/10ps
`default_nettype none
`include "crf_map.svh"
module crf_fp_classify
  import crf_pkg::*;
(
  // operand
  input  wire logic [63:0]  i_operand,
  input  wire logic         i_is_double,
  // class
  output crf_fpclass_t      o_class
);
  crf_single_t s;
  crf_double_t d;
  always_comb begin
    s = crf_single_t'(i_operand[31:0]);
    d = crf_double_t'(i_operand);
    if (i_is_double) begin
      o_class.trap = ((d.exp == 11'h000) && (d.frac != 52'h0)) || (d.exp == `CRF_DBL_EXP_MAX);
      o_class.zero = (d.exp == 11'h000) && (d.frac == 52'h0);
      o_class.sign = d.sign;
    end else begin
      o_class.trap = ((s.exp == 8'h00) && (s.frac != 23'h0)) || (s.exp == `CRF_SGL_EXP_MAX);
      o_class.zero = (s.exp == 8'h00) && (s.frac == 23'h0);
      o_class.sign = s.sign;
    end
  end
endmodule : crf_fp_classify
`default_nettype wire

/* hw/crf_alu64.sv */
// 32 and 64-bit add and subtract, signed and unsigned
`timescale 1ns/10ps
`default_nettype none
module crf_alu64
  import crf_pkg::*;
(
  // operands
  input  wire logic [63:0]  i_a,
  input  wire logic [63:0]  i_b,
  input  wire crf_aluop_t   i_op,
  input  wire logic         i_wide,
  // result
  output logic [63:0]       o_res,
  output logic              o_ovf
);
  logic [64:0] sum;
  logic [32:0] sum32;
  logic        sub;
  always_comb begin
    sub   = (i_op == CRF_ALU_SUBS) || (i_op == CRF_ALU_SUBU);
    sum   = {1'b0, i_a} + {1'b0, (sub ? ~i_b : i_b)} + {64'h0, sub};
    sum32 = {1'b0, i_a[31:0]} + {1'b0, (sub ? ~i_b[31:0] : i_b[31:0])} + {32'h0, sub};
    if (i_wide) begin
      o_res = sum[63:0];
      case (i_op)
        CRF_ALU_ADDS, CRF_ALU_SUBS: o_ovf = (i_a[63] == (sub ? ~i_b[63] : i_b[63])) && (sum[63] != i_a[63]);
        CRF_ALU_ADDU: o_ovf = sum[64];
        default:      o_ovf = ~sum[64];
      endcase
    end else begin
      o_res = {32'h0, sum32[31:0]};
      case (i_op)
        CRF_ALU_ADDS, CRF_ALU_SUBS: o_ovf = (i_a[31] == (sub ? ~i_b[31] : i_b[31])) && (sum32[31] != i_a[31]);
        CRF_ALU_ADDU: o_ovf = sum32[32];
        default:      o_ovf = ~sum32[32];
      endcase
    end
  end
endmodule : crf_alu64
`default_nettype wire

/* hw/crf_top.sv */
// integer and floating register files with operand formatting
`timescale 1ns/10ps
`default_nettype none
`include "crf_map.svh"
module crf_top
  import crf_pkg::*;
(
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  // integer register access
  input  wire logic [4:0]   i_ir_rd_a,
  input  wire logic [4:0]   i_ir_rd_b,
  input  wire logic         i_ir_we,
  input  wire logic [4:0]   i_ir_wa,
  input  wire logic [31:0]  i_ir_wd,
  output logic [31:0]       o_ir_a,
  output logic [31:0]       o_ir_b,
  // integer alu
  input  wire logic         i_alu_go,
  input  wire crf_aluop_t   i_alu_op,
  input  wire logic         i_alu_wide,
  input  wire logic [4:0]   i_alu_dst,
  output logic [63:0]       o_alu_res,
  output logic              o_alu_ovf,
  // integer memory load and store
  input  wire logic         i_ld_go,
  input  wire logic [1:0]   i_ld_size,
  input  wire logic [4:0]   i_ld_dst,
  input  wire logic [31:0]  i_ld_data,
  input  wire logic         i_st_go,
  input  wire logic [1:0]   i_st_size,
  input  wire logic [4:0]   i_st_src,
  output logic [31:0]       o_st_data,
  output logic [3:0]        o_st_be,
  // floating register access, 128-bit data path
  input  wire logic [4:0]   i_fr_rd,
  input  wire logic [1:0]   i_fr_rd_size,
  output logic [127:0]      o_fr_rdata,
  input  wire logic         i_fr_we,
  input  wire logic [4:0]   i_fr_wa,
  input  wire logic [1:0]   i_fr_wsize,
  input  wire logic [127:0] i_fr_wd,
  // floating operand check
  input  wire logic         i_fp_go,
  input  wire logic [4:0]   i_fp_src,
  input  wire logic         i_fp_double,
  output logic              o_fp_trap,
  output logic              o_fp_zero,
  output logic              o_fp_sign,
  // pixel word
  input  wire logic         i_px_go,
  input  wire logic [1:0]   i_px_size,
  input  wire logic [4:0]   i_px_src,
  output logic [63:0]       o_px_word,
  output logic [7:0]        o_px_field_a,
  output logic [7:0]        o_px_field_b,
  output logic [7:0]        o_px_field_c,
  output logic [7:0]        o_px_attr,
  // control and concurrency registers
  input  wire logic         i_ctl_ld,
  input  wire logic         i_ctl_st,
  input  wire logic [3:0]   i_ctl_num,
  input  wire logic [31:0]  i_ctl_wd,
  output logic [31:0]       o_ctl_rd,
  input  wire logic         i_cc_mem_we,
  input  wire logic         i_cc_mem_sel,
  input  wire logic [31:0]  i_cc_mem_wd,
  output logic [31:0]       o_cc_mem_rd
);
  logic [31:0]  ireg_q [`CRF_NREG];
  logic [31:0]  freg_q [`CRF_NREG];
  logic [31:0]  ctl_q  [`CRF_CTL_NUM];
  logic [31:0]  next_task_pointer_reg_q;
  logic [31:0]  cc_status_q;
  logic [31:0]  ld_ext;
  logic [31:0]  st_word;
  logic [63:0]  alu_a;
  logic [63:0]  alu_b;
  logic [63:0]  alu_res;
  logic         alu_ovf;
  logic [63:0]  fp_opnd;
  logic [63:0]  px_src;
  crf_fpclass_t fpc;
  logic [4:0]   fbase;

  function automatic logic [31:0] ird(input logic [4:0] a);
    ird = (a == 5'h00) ? 32'h0 : ireg_q[a];
  endfunction : ird

  function automatic logic [31:0] frd(input logic [4:0] a);
    frd = (a[4:1] == 4'h0) ? 32'h0 : freg_q[a];
  endfunction : frd

  // sign extend narrow loads
  always_comb begin
    case (i_ld_size)
      `CRF_SZ_B: ld_ext = {{24{i_ld_data[7]}}, i_ld_data[7:0]};
      `CRF_SZ_H: ld_ext = {{16{i_ld_data[15]}}, i_ld_data[15:0]};
      default:   ld_ext = i_ld_data;
    endcase
  end

  // store source word, cut to the store size below
  always_comb begin
    st_word = ird(i_st_src);
  end

  // 64-bit operands: even/odd integer pair, low word at lower index
  always_comb begin
    alu_a = {ird({i_ir_rd_a[4:1], 1'b1}), ird({i_ir_rd_a[4:1], 1'b0})};
    alu_b = {ird({i_ir_rd_b[4:1], 1'b1}), ird({i_ir_rd_b[4:1], 1'b0})};
    if (!i_alu_wide) begin
      alu_a = {32'h0, ird(i_ir_rd_a)};
      alu_b = {32'h0, ird(i_ir_rd_b)};
    end
  end

  crf_alu64 u_alu (
    .i_a   (alu_a),
    .i_b   (alu_b),
    .i_op  (i_alu_op),
    .i_wide(i_alu_wide),
    .o_res (alu_res),
    .o_ovf (alu_ovf)
  );

  // integer file writes; index zero writes are dropped
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int i = 0; i < `CRF_NREG; i++) begin
        ireg_q[i] <= 32'h0;
      end
    end else begin
      if (i_ir_we && (i_ir_wa != 5'h00)) begin
        ireg_q[i_ir_wa] <= i_ir_wd;
      end
      if (i_ld_go && (i_ld_dst != 5'h00)) begin
        ireg_q[i_ld_dst] <= ld_ext;
      end
      if (i_alu_go && i_alu_wide) begin
        if ({i_alu_dst[4:1], 1'b0} != 5'h00) begin
          ireg_q[{i_alu_dst[4:1], 1'b0}] <= alu_res[31:0];
        end
        ireg_q[{i_alu_dst[4:1], 1'b1}] <= alu_res[63:32];
      end else if (i_alu_go && (i_alu_dst != 5'h00)) begin
        ireg_q[i_alu_dst] <= alu_res[31:0];
      end
    end
  end

  // floating writes: 32, 64 or 128 bits, lowest register gets lowest part
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int i = 0; i < `CRF_NREG; i++) begin
        freg_q[i] <= 32'h0;
      end
    end else if (i_fr_we) begin
      for (int k = 0; k < 4; k++) begin
        if ((k == 0) || (k == 1 && i_fr_wsize != `CRF_SZ_W) ||
            (k >= 2 && i_fr_wsize == 2'h3)) begin
          freg_q[i_fr_wa + 5'(k)] <= i_fr_wd[32*k +: 32];
        end
      end
    end
  end

  // floating reads, grouped by size
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_fr_rdata <= 128'h0;
    end else begin
      case (i_fr_rd_size)
        `CRF_SZ_W: o_fr_rdata <= {96'h0, frd(i_fr_rd)};
        `CRF_SZ_H: o_fr_rdata <= {64'h0, frd({i_fr_rd[4:1], 1'b1}), frd({i_fr_rd[4:1], 1'b0})};
        default:   o_fr_rdata <= {frd({i_fr_rd[4:2], 2'h3}), frd({i_fr_rd[4:2], 2'h2}),
                                  frd({i_fr_rd[4:2], 2'h1}), frd({i_fr_rd[4:2], 2'h0})};
      endcase
    end
  end

  // integer outputs and stores
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_ir_a    <= 32'h0;
      o_ir_b    <= 32'h0;
      o_st_data <= 32'h0;
      o_st_be   <= 4'h0;
      o_alu_res <= 64'h0;
      o_alu_ovf <= 1'b0;
    end else begin
      o_ir_a <= ird(i_ir_rd_a);
      o_ir_b <= ird(i_ir_rd_b);
      if (i_alu_go) begin
        o_alu_res <= alu_res;
        o_alu_ovf <= alu_ovf;
      end
      if (i_st_go) begin
        case (i_st_size)
          `CRF_SZ_B: begin
            o_st_data <= {24'h0, st_word[7:0]};
            o_st_be   <= 4'h1;
          end
          `CRF_SZ_H: begin
            o_st_data <= {16'h0, st_word[15:0]};
            o_st_be   <= 4'h3;
          end
          default: begin
            o_st_data <= st_word;
            o_st_be   <= 4'hf;
          end
        endcase
      end else begin
        o_st_be <= 4'h0;
      end
    end
  end

  // floating operand source check
  always_comb begin
    fbase   = {i_fp_src[4:1], i_fp_src[0] & ~i_fp_double};
    fp_opnd = i_fp_double ? {frd({fbase[4:1], 1'b1}), frd(fbase)} : {32'h0, frd(fbase)};
  end

  crf_fp_classify u_cls (
    .i_operand  (fp_opnd),
    .i_is_double(i_fp_double),
    .o_class    (fpc)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_fp_trap <= 1'b0;
      o_fp_zero <= 1'b0;
      o_fp_sign <= 1'b0;
    end else begin
      o_fp_trap <= i_fp_go & fpc.trap;
      o_fp_zero <= i_fp_go & fpc.zero;
      o_fp_sign <= fpc.sign;
    end
  end

  // pixel word: always a full 64 bits, fields of first pixel
  always_comb begin
    px_src = {frd({i_px_src[4:1], 1'b1}), frd({i_px_src[4:1], 1'b0})};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_px_word    <= 64'h0;
      o_px_field_a <= 8'h0;
      o_px_field_b <= 8'h0;
      o_px_field_c <= 8'h0;
      o_px_attr    <= 8'h0;
    end else if (i_px_go) begin
      o_px_word <= px_src;
      case (i_px_size)
        `CRF_PS_16: begin
          o_px_field_a <= {4'h0, px_src[3:0]};
          o_px_field_b <= {2'h0, px_src[9:4]};
          o_px_field_c <= {2'h0, px_src[15:10]};
          o_px_attr    <= 8'h0;
        end
        `CRF_PS_32: begin
          o_px_field_a <= px_src[7:0];
          o_px_field_b <= px_src[15:8];
          o_px_field_c <= px_src[23:16];
          o_px_attr    <= px_src[31:24];
        end
        default: begin
          o_px_field_a <= px_src[7:0];
          o_px_field_b <= 8'h0;
          o_px_field_c <= 8'h0;
          o_px_attr    <= 8'h0;
        end
      endcase
    end
  end

  // control registers: only control load and store reach them
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int i = 0; i < `CRF_CTL_NUM; i++) begin
        ctl_q[i] <= 32'h0;
      end
      o_ctl_rd <= 32'h0;
    end else begin
      if (i_ctl_st && (i_ctl_num < `CRF_CTL_NUM)) begin
        ctl_q[i_ctl_num] <= i_ctl_wd;
      end
      if (i_ctl_ld && (i_ctl_num < `CRF_CTL_NUM)) begin
        o_ctl_rd <= ctl_q[i_ctl_num];
      end
    end
  end

  // concurrency registers on the ordinary memory path
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      next_task_pointer_reg_q <= 32'h0;
      cc_status_q             <= 32'h0;
      o_cc_mem_rd             <= 32'h0;
    end else begin
      if (i_cc_mem_we && !i_cc_mem_sel) begin
        next_task_pointer_reg_q <= i_cc_mem_wd;
      end
      if (i_cc_mem_we && i_cc_mem_sel) begin
        cc_status_q <= i_cc_mem_wd;
      end
      o_cc_mem_rd <= i_cc_mem_sel ? cc_status_q : next_task_pointer_reg_q;
    end
  end

  // checks
  a_int_zero_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ir_rd_a == 5'h00) |=> (o_ir_a == 32'h0)) else $error("int zero reg read nonzero");
  a_fp_zero_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_fr_rd_size == `CRF_SZ_W && i_fr_rd[4:1] == 4'h0) |=> (o_fr_rdata == 128'h0))
    else $error("fp zero reg read nonzero");
  a_int_write_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ir_we && i_ir_wa != 5'h00 && !i_ld_go && !i_alu_go && i_ir_rd_a == i_ir_wa ##1 i_ir_rd_a == $past(i_ir_wa))
    |=> (o_ir_a == $past(i_ir_wd, 2))) else $error("int write not visible");
  a_ld_sign_byte: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ld_go && i_ld_size == `CRF_SZ_B) |-> (ld_ext[31:8] == {24{i_ld_data[7]}}))
    else $error("byte load not sign extended");
  a_st_half_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_st_go && i_st_size == `CRF_SZ_H) |=> (o_st_be == 4'h3 && o_st_data[31:16] == 16'h0))
    else $error("half store wrong lanes");
  a_fp_trap_exp: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_fp_go && !i_fp_double && fp_opnd[30:23] == 8'hff) |=> o_fp_trap)
    else $error("all ones exponent did not trap");
  a_fp_zero_notrap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_fp_go && i_fp_double && fp_opnd[62:0] == 63'h0) |=> (o_fp_zero && !o_fp_trap && o_fp_sign == $past(fp_opnd[63])))
    else $error("signed zero mishandled");
  a_alu_addu_wide: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_alu_go && i_alu_wide && i_alu_op == CRF_ALU_ADDU) |=> (o_alu_res == $past(alu_a) + $past(alu_b)))
    else $error("64-bit add wrong");
  a_px_word_full: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_px_go |=> (o_px_word == $past(px_src))) else $error("pixel word not 64 bits");
  c_quad_read: cover property (@(posedge i_clk_sys) disable iff (i_reset) (i_fr_rd_size == 2'h3 && i_fr_rd == 5'h1c));
  c_fp_trap: cover property (@(posedge i_clk_sys) disable iff (i_reset) o_fp_trap);
  c_wide_sub: cover property (@(posedge i_clk_sys) disable iff (i_reset) (i_alu_go && i_alu_wide && i_alu_op == CRF_ALU_SUBS));
  c_zero_write: cover property (@(posedge i_clk_sys) disable iff (i_reset) (i_ir_we && i_ir_wa == 5'h00));
endmodule : crf_top
`default_nettype wire

/* dv/crf_dcache_model.sv */
// behavioural data cache word store facing the load and store ports
`timescale 1ns/10ps
`default_nettype none
module crf_dcache_model (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // access from the register files
  input  wire logic [1:0]  i_addr,
  input  wire logic [31:0] i_st_data,
  input  wire logic [3:0]  i_st_be,
  output logic [31:0]      o_ld_data
);
  logic [31:0] mem_q [4];
  assign o_ld_data = mem_q[i_addr];
  // only enabled byte lanes of a store reach memory
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mem_q[0] <= 32'h1234_56f0;
      mem_q[1] <= 32'h0000_8001;
      mem_q[2] <= 32'h0000_007f;
      mem_q[3] <= 32'h8765_4321;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (i_st_be[k]) begin
          mem_q[i_addr][8*k +: 8] <= i_st_data[8*k +: 8];
        end
      end
    end
  end
endmodule : crf_dcache_model
`default_nettype wire

/* dv/crf_top_tb.sv */
// self-checking bench for the register files and operand formats
`timescale 1ns/10ps
`default_nettype none
module crf_top_tb;
  import crf_pkg::*;
  logic i_clk_sys, i_reset, ir_we, alu_go, alu_wide, ld_go, st_go, fr_we, fp_go, fp_dbl, px_go, ctl_ld, ctl_st;
  logic cc_we, cc_sel;
  logic [4:0] rd_a, rd_b, ir_wa, alu_dst, ld_dst, st_src, fr_rd, fr_wa, fp_src, px_src;
  logic [1:0] ld_sz, st_sz, fr_rsz, fr_wsz, px_sz, addr;
  logic [31:0] ir_wd, ld_data, ctl_wd, cc_wd, ir_a, ir_b, st_data, ctl_rd, cc_rd;
  logic [127:0] fr_wd, fr_rdata;
  logic [63:0] alu_res, px_word;
  logic [7:0] fa, fb, fc, fattr;
  logic [3:0] st_be, ctl_num;
  logic alu_ovf, fp_trap, fp_zero, fp_sign;
  crf_aluop_t alu_op;
  int mismatches, n_compared;

  crf_top dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ir_rd_a(rd_a), .i_ir_rd_b(rd_b), .i_ir_we(ir_we),
    .i_ir_wa(ir_wa), .i_ir_wd(ir_wd), .o_ir_a(ir_a), .o_ir_b(ir_b), .i_alu_go(alu_go), .i_alu_op(alu_op),
    .i_alu_wide(alu_wide), .i_alu_dst(alu_dst), .o_alu_res(alu_res), .o_alu_ovf(alu_ovf), .i_ld_go(ld_go),
    .i_ld_size(ld_sz), .i_ld_dst(ld_dst), .i_ld_data(ld_data), .i_st_go(st_go), .i_st_size(st_sz),
    .i_st_src(st_src), .o_st_data(st_data), .o_st_be(st_be), .i_fr_rd(fr_rd), .i_fr_rd_size(fr_rsz),
    .o_fr_rdata(fr_rdata), .i_fr_we(fr_we), .i_fr_wa(fr_wa), .i_fr_wsize(fr_wsz), .i_fr_wd(fr_wd),
    .i_fp_go(fp_go), .i_fp_src(fp_src), .i_fp_double(fp_dbl), .o_fp_trap(fp_trap), .o_fp_zero(fp_zero),
    .o_fp_sign(fp_sign), .i_px_go(px_go), .i_px_size(px_sz), .i_px_src(px_src), .o_px_word(px_word),
    .o_px_field_a(fa), .o_px_field_b(fb), .o_px_field_c(fc), .o_px_attr(fattr), .i_ctl_ld(ctl_ld),
    .i_ctl_st(ctl_st), .i_ctl_num(ctl_num), .i_ctl_wd(ctl_wd), .o_ctl_rd(ctl_rd), .i_cc_mem_we(cc_we),
    .i_cc_mem_sel(cc_sel), .i_cc_mem_wd(cc_wd), .o_cc_mem_rd(cc_rd));
  crf_dcache_model u_mem (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(addr), .i_st_data(st_data),
    .i_st_be(st_be), .o_ld_data(ld_data));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic tk();
    @(negedge i_clk_sys);
  endtask : tk

  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic wr_int(input logic [4:0] a, input logic [31:0] d);
    ir_we = 1'b1; ir_wa = a; ir_wd = d; tk(); ir_we = 1'b0; tk();
  endtask : wr_int

  task automatic rd_int(input logic [4:0] a, input logic [31:0] exp, input string what);
    rd_a = a; tk(); tk(); chk(ir_a, exp, what);
  endtask : rd_int

  task automatic wr_fp(input logic [4:0] a, input logic [1:0] sz, input logic [127:0] d);
    fr_we = 1'b1; fr_wa = a; fr_wsz = sz; fr_wd = d; tk(); fr_we = 1'b0;
  endtask : wr_fp

  task automatic rd_fp(input logic [4:0] a, input logic [1:0] sz, input logic [127:0] msk, input logic [127:0] exp);
    fr_rd = a; fr_rsz = sz; tk(); tk(); chk(fr_rdata & msk, exp, "fp read");
  endtask : rd_fp

  task automatic t_int_zero();
    wr_int(5'h00, 32'hffff_ffff);
    rd_a = 5'h05;
    wr_int(5'h05, 32'ha5a5_0001);
    rd_int(5'h05, 32'ha5a5_0001, "r5 port a");
    rd_b = 5'h05;
    rd_int(5'h00, 32'h0, "r zero");
    chk(ir_b, 32'ha5a5_0001, "r5");
    $display("test int_zero done");
  endtask : t_int_zero

  task automatic t_fp_groups();
    logic [127:0] v;
    v = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
    wr_fp(5'h00, 2'h3, v);
    rd_fp(5'h00, 2'h3, '1, {v[127:64], 64'h0});
    rd_fp(5'h01, 2'h2, '1, 128'h0);
    wr_fp(5'h1c, 2'h3, v);
    rd_fp(5'h1c, 2'h3, '1, v);
    rd_fp(5'h1e, 2'h1, {64'h0, {64{1'b1}}}, {64'h0, v[127:64]});
    rd_fp(5'h1d, 2'h2, {96'h0, 32'hffff_ffff}, {96'h0, v[63:32]});
    $display("test fp_groups done");
  endtask : t_fp_groups

  task automatic t_load_store();
    logic [31:0] exp [4] = '{32'hffff_fff0, 32'hffff_8001, 32'h0000_007f, 32'h8765_4321};
    logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
    for (int k = 0; k < 4; k++) begin
      addr = 2'(k); ld_sz = sz[k]; ld_dst = 5'(6 + k); ld_go = 1'b1; tk(); ld_go = 1'b0;
      rd_int(5'(6 + k), exp[k], "load");
    end
    for (int k = 0; k < 2; k++) begin
      addr = 2'(k); st_sz = 2'(k); st_src = 5'h09; st_go = 1'b1; tk(); st_go = 1'b0;
      chk(st_data, k ? 32'h0000_4321 : 32'h0000_0021, "store data");
      chk(st_be, k ? 4'h3 : 4'h1, "store lanes");
      tk();
      chk(ld_data, k ? 32'h0000_4321 : 32'h1234_5621, "memory after store");
      chk(st_be, 4'h0, "store lanes idle");
    end
    $display("test load_store done");
  endtask : t_load_store

  task automatic fp_case(input logic dbl, input logic [63:0] v, input logic [2:0] exp);
    wr_fp(5'h02, dbl ? 2'h1 : 2'h2, {64'h0, v});
    fp_src = 5'h02; fp_dbl = dbl; fp_go = 1'b1; tk(); fp_go = 1'b0;
    chk({fp_trap, fp_zero, fp_sign}, exp, "fp class");
    tk();
    chk({fp_trap, fp_zero}, 2'b00, "fp pulse end");
  endtask : fp_case

  task automatic t_fp_class();
    fp_case(1'b0, 64'h8000_0000, 3'b011);
    fp_case(1'b0, 64'h0000_0001, 3'b100);
    fp_case(1'b0, 64'hff80_0001, 3'b101);
    fp_case(1'b0, 64'h0080_0000, 3'b000);
    fp_case(1'b1, 64'h7ff0_0000_0000_0000, 3'b100);
    fp_case(1'b1, 64'h0000_0000_0000_0001, 3'b100);
    fp_case(1'b1, 64'h8000_0000_0000_0000, 3'b011);
    fp_case(1'b1, 64'h3ff0_0000_0000_0000, 3'b000);
    $display("test fp_class done");
  endtask : t_fp_class

  task automatic alu_case(input crf_aluop_t op, input logic w, input logic [63:0] a, input logic [63:0] b,
                          input logic [63:0] exp, input logic ovf);
    logic [63:0] m;
    m = w ? '1 : 64'h0000_0000_ffff_ffff;
    wr_int(5'h02, a[31:0]); wr_int(5'h03, a[63:32]); wr_int(5'h04, b[31:0]); wr_int(5'h05, b[63:32]);
    rd_a = 5'h02; rd_b = 5'h04; tk();
    alu_op = op; alu_wide = w; alu_dst = 5'h0a; alu_go = 1'b1; tk(); alu_go = 1'b0; tk();
    chk(alu_res & m, exp & m, "alu result");
    chk(alu_ovf, ovf, "alu overflow");
    rd_int(5'h0a, exp[31:0], "alu dest");
  endtask : alu_case

  task automatic t_alu();
    alu_case(CRF_ALU_ADDS, 1'b0, 64'h7fff_ffff, 64'h1, 64'h8000_0000, 1'b1);
    alu_case(CRF_ALU_SUBS, 1'b0, 64'h8000_0000, 64'h1, 64'h7fff_ffff, 1'b1);
    alu_case(CRF_ALU_SUBU, 1'b0, 64'h0, 64'h1, 64'hffff_ffff, 1'b1);
    alu_case(CRF_ALU_ADDU, 1'b1, '1, 64'h1, 64'h0, 1'b1);
    alu_case(CRF_ALU_SUBU, 1'b1, 64'h1_0000_0000, 64'h1, 64'hffff_ffff, 1'b0);
    alu_case(CRF_ALU_ADDS, 1'b1, 64'h7fff_ffff_ffff_ffff, 64'h1, 64'h8000_0000_0000_0000, 1'b1);
    $display("test alu done");
  endtask : t_alu

  task automatic t_pixel();
    wr_fp(5'h06, 2'h1, {64'h0, 64'h1234_5678_9abc_def0});
    for (int k = 0; k < 3; k++) begin
      px_src = 5'h06; px_sz = 2'(k); px_go = 1'b1; tk(); px_go = 1'b0; tk();
      chk(px_word, 64'h1234_5678_9abc_def0, "pixel word");
      if (k == 0) chk(fa, 8'hf0, "pixel 8 field");
      if (k == 1) chk({fa, fb, fc}, 24'h00_2f_37, "pixel 16 fields");
      if (k == 2) chk({fa, fb, fc, fattr}, 32'hf0_de_bc_9a, "pixel 32 fields");
    end
    $display("test pixel done");
  endtask : t_pixel

  task automatic t_ctl_cc();
    ctl_num = 4'h3; ctl_wd = 32'hdead_beef; ctl_st = 1'b1; tk(); ctl_st = 1'b0;
    cc_sel = 1'b0; cc_wd = 32'h0000_1000; cc_we = 1'b1; tk();
    cc_sel = 1'b1; cc_wd = 32'h0000_0002; tk(); cc_we = 1'b0;
    cc_sel = 1'b0; tk(); tk();
    chk(cc_rd, 32'h0000_1000, "next task pointer");
    cc_sel = 1'b1; tk(); tk();
    chk(cc_rd, 32'h0000_0002, "concurrency status");
    ctl_ld = 1'b1; tk(); ctl_ld = 1'b0; tk();
    chk(ctl_rd, 32'hdead_beef, "control read");
    $display("test ctl_cc done");
  endtask : t_ctl_cc

  initial begin
    {ir_we, alu_go, alu_wide, ld_go, st_go, fr_we, fp_go, fp_dbl, px_go, ctl_ld, ctl_st, cc_we, cc_sel} = '0;
    {rd_a, rd_b, ir_wa, alu_dst, ld_dst, st_src, fr_rd, fr_wa, fp_src, px_src} = '0;
    {ld_sz, st_sz, fr_rsz, fr_wsz, px_sz, addr, ctl_num} = '0;
    {ir_wd, ctl_wd, cc_wd, fr_wd} = '0;
    alu_op = CRF_ALU_ADDS;
    mismatches = 0;
    n_compared = 0;
    i_reset = 1'b1;
    repeat (5) tk();
    i_reset = 1'b0;
    chk(alu_res, 64'h0, "alu after reset");
    t_int_zero();
    t_fp_groups();
    t_load_store();
    t_fp_class();
    t_alu();
    t_pixel();
    t_ctl_cc();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    $display("[ERR] %0t run limit reached", $time);
    end_sim();
  end
endmodule : crf_top_tb
`default_nettype wire
